// ===== hw/bgc_ber_gating_counter.sv
// Gated bit-error measurement controller with AXI4-Lite registers
`timescale 1ns/1ps
module bgc_ber_gating_counter import bgc_pkg::*; #(
	parameter int unsigned SEC_CYCLES  = CYC_SEC,
	parameter int unsigned LIVE_CYCLES = CYC_LIVE
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	// AXI4-Lite write address and data
	input  wire logic        i_axi_awvalid,
	output logic             o_axi_awready,
	input  wire logic [7:0]  i_axi_awaddr,
	input  wire logic        i_axi_wvalid,
	output logic             o_axi_wready,
	input  wire logic [31:0] i_axi_wdata,
	input  wire logic [3:0]  i_axi_wstrb,
	// AXI4-Lite write response
	output logic             o_axi_bvalid,
	input  wire logic        i_axi_bready,
	output logic [1:0]       o_axi_bresp,
	// AXI4-Lite read
	input  wire logic        i_axi_arvalid,
	output logic             o_axi_arready,
	input  wire logic [7:0]  i_axi_araddr,
	output logic             o_axi_rvalid,
	input  wire logic        i_axi_rready,
	output logic [31:0]      o_axi_rdata,
	output logic [1:0]       o_axi_rresp,
	// Compared bit stream from the error detector
	input  wire logic        i_bit_valid,
	input  wire logic        i_bit_error,
	// Asynchronous status pins
	input  wire logic        i_clock_recovered,
	input  wire logic        i_pattern_synced,
	input  wire logic        i_low_rate_fitted,
	// Status outputs
	output logic             o_running,
	output logic             o_error_alarm,
	output logic             o_recovery_unlocked_alarm,
	output logic             o_pattern_unlocked_alarm
);

	//------------------------------------------------------------------
	// Pin synchronisation
	//------------------------------------------------------------------
	bgc_pins_t pins;

	bgc_pin_sync #(
		.W(3)
	) u_sync (
		.i_sys_clk (i_sys_clk),
		.i_reset_n (i_reset_n),
		.i_pin     ({i_clock_recovered, i_pattern_synced, i_low_rate_fitted}),
		.o_level   (pins)
	);

	//------------------------------------------------------------------
	// Helpers
	//------------------------------------------------------------------
	// Decimal decade of a count: 1000..9999 gives 3
	function automatic logic [4:0] decade(input logic [59:0] v);
		logic [63:0] p;
		logic [4:0]  d;
		p = 64'h000000000000000A;
		d = 5'h00;
		for (int i = 0; i < 18; i++) begin
			if ({4'h0, v} >= p) begin
				d = d + 5'h01;
			end
			p = p * 64'h000000000000000A;
		end
		return d;
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old,
	                                     input logic [31:0] nw,
	                                     input logic [3:0]  be);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (be[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic [59:0] sat_inc(input logic [59:0] v);
		return (v >= TOT_MAX) ? TOT_MAX : v + 60'h1;
	endfunction

	//------------------------------------------------------------------
	// State
	//------------------------------------------------------------------
	bgc_state_t q;
	bgc_state_t next_q;

	logic        running;
	logic        sec_tick;
	logic        live_tick;
	logic        period_end;
	logic        do_wr;
	logic        wr_ctrl;
	logic        start_cmd;
	logic        stop_cmd;
	logic        hclr_cmd;
	logic        publish;
	logic [31:0] ctrl_word;
	logic [31:0] status_word;
	logic [31:0] ratio_word;
	logic [19:0] remain;
	logic [19:0] wr_period;
	logic [4:0]  dec_bits;
	logic [4:0]  dec_err;
	logic        rec_alarm;
	logic        bad_addr;
	logic [31:0] rd_mux;

	always_comb begin
		running    = (q.st == ST_RUN);
		sec_tick   = running && (q.tick == SEC_CYCLES - 1);
		live_tick  = (q.live_cnt == LIVE_CYCLES - 1);
		period_end = sec_tick && (q.mode != GATE_UNTIMED)
		             && (q.elapsed + 20'h1 >= q.period);
		do_wr      = q.aw_held && q.w_held && !q.bvalid;
		wr_ctrl    = do_wr && (q.awaddr == OFS_CTRL) && q.wstrb[0];
		start_cmd  = wr_ctrl && q.wdata[CTRL_START];
		stop_cmd   = wr_ctrl && q.wdata[CTRL_STOP] && !q.wdata[CTRL_START];
		hclr_cmd   = wr_ctrl && q.wdata[CTRL_HCLR];
		// Period only moves in the timed modes, clamped to its range
		wr_period  = q.wdata[19:0];
		if (wr_period < PERIOD_MIN) begin
			wr_period = PERIOD_MIN;
		end else if (wr_period > PERIOD_MAX) begin
			wr_period = PERIOD_MAX;
		end
		// Unlock indication, qualified by rate, option and sync
		rec_alarm = !pins.rec_ok && (q.div <= 3'h1)
		            && !(pins.low_fit && q.bitrate <= LOWRATE_KBPS)
		            && !(running && q.sync_seen);
		// Live refresh, or period end, or untimed stop
		publish = q.live ? live_tick
		          : (period_end
		             || (stop_cmd && running && q.mode == GATE_UNTIMED));
		remain = (q.mode == GATE_UNTIMED) ? 20'h0
		         : q.period - q.elapsed;
	end

	//------------------------------------------------------------------
	// Result formatting
	//------------------------------------------------------------------
	always_comb begin
		dec_bits = decade(q.pub_bits);
		dec_err  = decade(q.pub_err);
		// Bit 31: zero mantissa; low bits: negative exponent magnitude
		if (q.pub_err == 60'h0) begin
			ratio_word = {1'b1, 26'h0, dec_bits};
		end else if (q.pub_err >= q.pub_bits) begin
			ratio_word = 32'h0;
		end else begin
			ratio_word = {27'h0, dec_bits - dec_err};
		end
		ctrl_word = {21'h0, q.div, 1'b0, q.live, q.mode, 4'h0};
		// Float-form flags tell software which reporting range applies
		status_word = {22'h0,
		               q.pub_bits > INT_MAX,
		               q.pub_err > INT_MAX,
		               q.hist, q.alarm, 1'b0, running};
	end

	always_comb begin
		bad_addr = 1'b0;
		unique case (i_axi_araddr)
			OFS_CTRL:     rd_mux = ctrl_word;
			OFS_PERIOD:   rd_mux = {12'h0, q.period};
			OFS_STATUS:   rd_mux = status_word;
			OFS_ELAPSED:  rd_mux = {12'h0, q.elapsed};
			OFS_REMAIN:   rd_mux = {12'h0, remain};
			OFS_ERR_LO:   rd_mux = q.pub_err[31:0];
			OFS_ERR_HI:   rd_mux = {4'h0, q.pub_err[59:32]};
			OFS_BITS_LO:  rd_mux = q.pub_bits[31:0];
			OFS_BITS_HI:  rd_mux = {4'h0, q.pub_bits[59:32]};
			OFS_RATIO:    rd_mux = ratio_word;
			OFS_RATE:     rd_mux = q.khz;
			OFS_PROGRESS: rd_mux = q.progress;
			OFS_BITRATE:  rd_mux = q.bitrate;
			default: begin
				rd_mux   = 32'h0;
				bad_addr = 1'b1;
			end
		endcase
	end

	//------------------------------------------------------------------
	// Next state
	//------------------------------------------------------------------
	always_comb begin
		next_q = q;

		// Time bases
		next_q.live_cnt = live_tick ? 32'h0 : q.live_cnt + 32'h1;
		if (running) begin
			next_q.tick = sec_tick ? 32'h0 : q.tick + 32'h1;
		end

		// Counting: errors and bits saturate at the floating ceiling
		if (running && i_bit_valid) begin
			next_q.bits = sat_inc(q.bits);
			if (i_bit_error) begin
				next_q.err = sat_inc(q.err);
			end
		end

		// Rate: one kHz per thousand bits within each second
		if (i_bit_valid) begin
			next_q.k_div = (q.k_div == BITS_PER_K - 10'h1) ? 10'h0
			               : q.k_div + 10'h1;
		end
		if (sec_tick) begin
			next_q.khz   = q.k_acc;
			next_q.k_acc = 32'h0;
		end else if (i_bit_valid && q.k_div == BITS_PER_K - 10'h1) begin
			next_q.k_acc = q.k_acc + 32'h1;
		end

		// Elapsed time and untimed progress
		if (sec_tick) begin
			next_q.elapsed = q.elapsed + 20'h1;
			if (q.mode == GATE_UNTIMED) begin
				next_q.prog_cnt = (q.prog_cnt == PROG_SEC - 3'h1) ? 3'h0
				                  : q.prog_cnt + 3'h1;
				if (q.prog_cnt == PROG_SEC - 3'h1) begin
					next_q.progress = {12'h0, q.elapsed + 20'h1};
				end
			end
		end

		if (publish) begin
			next_q.pub_err  = next_q.err;
			next_q.pub_bits = next_q.bits;
		end

		// Period boundary
		if (period_end) begin
			next_q.elapsed = 20'h0;
			if (q.mode == GATE_SINGLE) begin
				next_q.st = ST_IDLE;
			end else begin
				next_q.err  = 60'h0;
				next_q.bits = 60'h0;
			end
		end

		// Alarms and history; a new alarm wins over a clear
		if (running && pins.sync_ok) begin
			next_q.sync_seen = 1'b1;
		end
		if (running && i_bit_valid && i_bit_error) begin
			next_q.err_win = 1'b1;
		end else if (live_tick) begin
			next_q.err_win = 1'b0;
		end
		next_q.alarm = {!pins.sync_ok && !q.sync_seen,
		                rec_alarm,
		                q.err_win};
		next_q.hist = (hclr_cmd ? 3'h0 : q.hist)
		              | q.alarm;

		// Commands
		if (start_cmd) begin
			next_q.st        = ST_RUN;
			next_q.err       = 60'h0;
			next_q.bits      = 60'h0;
			next_q.elapsed   = 20'h0;
			next_q.tick      = 32'h0;
			next_q.prog_cnt  = 3'h0;
			next_q.progress  = 32'h0;
			next_q.sync_seen = 1'b0;
		end else if (stop_cmd) begin
			next_q.st = ST_IDLE;
		end

		// Configuration writes
		if (wr_ctrl && !running) begin
			if (q.wdata[CTRL_MODE +: 2] != 2'b11) begin
				next_q.mode = bgc_mode_t'(q.wdata[CTRL_MODE +: 2]);
			end
			next_q.live = q.wdata[CTRL_LIVE];
		end
		if (do_wr && q.awaddr == OFS_CTRL && q.wstrb[1]) begin
			next_q.div = q.wdata[CTRL_DIV +: 3];
		end
		if (do_wr && q.awaddr == OFS_PERIOD && !running
		    && q.mode != GATE_UNTIMED) begin
			next_q.period = 20'(merge({12'h0, q.period},
			                          {12'h0, wr_period}, q.wstrb));
		end
		if (do_wr && q.awaddr == OFS_BITRATE) begin
			next_q.bitrate = merge(q.bitrate, q.wdata, q.wstrb);
		end

		// AXI4-Lite write channel
		if (i_axi_awvalid && o_axi_awready) begin
			next_q.aw_held = 1'b1;
			next_q.awaddr  = {i_axi_awaddr[7:2], 2'b00};
		end
		if (i_axi_wvalid && o_axi_wready) begin
			next_q.w_held = 1'b1;
			next_q.wdata  = i_axi_wdata;
			next_q.wstrb  = i_axi_wstrb;
		end
		if (do_wr) begin
			next_q.aw_held = 1'b0;
			next_q.w_held  = 1'b0;
			next_q.bvalid  = 1'b1;
			unique case (q.awaddr)
				OFS_CTRL, OFS_PERIOD, OFS_BITRATE: next_q.bresp = RESP_OKAY;
				default:                          next_q.bresp = RESP_SLVERR;
			endcase
		end else if (q.bvalid && i_axi_bready) begin
			next_q.bvalid = 1'b0;
		end

		// AXI4-Lite read channel
		if (i_axi_arvalid && !q.rvalid) begin
			next_q.rvalid = 1'b1;
			next_q.rdata  = rd_mux;
			next_q.rresp  = bad_addr ? RESP_SLVERR : RESP_OKAY;
		end else if (q.rvalid && i_axi_rready) begin
			next_q.rvalid = 1'b0;
		end
	end

	//------------------------------------------------------------------
	// Registers
	//------------------------------------------------------------------
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q         <= '0;
			q.st      <= ST_IDLE;
			q.mode    <= GATE_SINGLE;
			q.period  <= PERIOD_RST;
			q.bitrate <= BITRATE_RST;
		end else begin
			q <= next_q;
		end
	end

	//------------------------------------------------------------------
	// Outputs
	//------------------------------------------------------------------
	assign o_axi_awready             = !q.aw_held && !q.bvalid;
	assign o_axi_wready              = !q.w_held && !q.bvalid;
	assign o_axi_bvalid              = q.bvalid;
	assign o_axi_bresp               = q.bresp;
	assign o_axi_arready             = !q.rvalid;
	assign o_axi_rvalid              = q.rvalid;
	assign o_axi_rdata               = q.rdata;
	assign o_axi_rresp               = q.rresp;
	assign o_running                 = running;
	assign o_error_alarm             = q.alarm[0];
	assign o_recovery_unlocked_alarm = q.alarm[1];
	assign o_pattern_unlocked_alarm  = q.alarm[2];

endmodule

// ===== hw/bgc_pkg.sv
// Package: constants, types and state record of the gated BER counter
//------------------------------------------------------------------
// Operation
//------------------------------------------------------------------
// Operation
// - Single mode stops itself after period
// - Repeat runs on, ratio restarts each period
// - Untimed runs on, errors accumulate continuously
// - Period 1 s to 9d23h59m59s, timed modes
// - Live update refreshes results every 100 ms
// - Otherwise update at period end or untimed stop
// - Untimed mode reports progress every 5 s
// - Elapsed time returns to zero past period
// - Remaining time is period minus elapsed, zero in untimed mode
// - Ratio up to 1, zero mantissa without errors
// - Zero ratio exponent follows bit count decade
// - Error total integer, then floating to 9.9999E17
// - Bit total uses same ranges as errors
// - Receive rate in kHz from bit total
// - Error alarm on detected bit error
// - Recovery alarm only at rates 1/1, 1/2
// - Low-rate option at 3125000 kbit/s suppresses it
// - Pattern alarm while pattern not synchronised
// - Alarm history latches after cause goes
// - History clear resets history flags whose alarm is inactive
// - Sync after start clears unlock indications
package bgc_pkg;

	//------------------------------------------------------------------
	// Timing
	//------------------------------------------------------------------
	localparam int unsigned CLK_HZ       = 50_000_000;
	localparam int unsigned SEC_MS       = 1000;
	localparam int unsigned LIVE_MS      = 100;
	localparam int unsigned CYC_SEC      = CLK_HZ / 1000 * SEC_MS;
	localparam int unsigned CYC_LIVE     = CLK_HZ / 1000 * LIVE_MS;
	localparam logic [2:0]  PROG_SEC     = 3'h5;
	localparam logic [19:0] PERIOD_MIN   = 20'h00001;
	localparam logic [19:0] PERIOD_MAX   = 20'hD2EFF;
	localparam logic [19:0] PERIOD_RST   = 20'h0003C;
	localparam logic [9:0]  BITS_PER_K   = 10'h3E8;
	localparam logic [31:0] LOWRATE_KBPS = 32'h002FAF08;
	localparam logic [59:0] TOT_MAX      = 60'hDE0B6B3A763FFFF;
	localparam logic [59:0] INT_MAX      = 60'h00000000098967F;

	//------------------------------------------------------------------
	// Register offsets and fields
	//------------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL     = 8'h00;
	localparam logic [7:0] OFS_PERIOD   = 8'h04;
	localparam logic [7:0] OFS_STATUS   = 8'h08;
	localparam logic [7:0] OFS_ELAPSED  = 8'h0C;
	localparam logic [7:0] OFS_REMAIN   = 8'h10;
	localparam logic [7:0] OFS_ERR_LO   = 8'h14;
	localparam logic [7:0] OFS_ERR_HI   = 8'h18;
	localparam logic [7:0] OFS_BITS_LO  = 8'h1C;
	localparam logic [7:0] OFS_BITS_HI  = 8'h20;
	localparam logic [7:0] OFS_RATIO    = 8'h24;
	localparam logic [7:0] OFS_RATE     = 8'h28;
	localparam logic [7:0] OFS_PROGRESS = 8'h2C;
	localparam logic [7:0] OFS_BITRATE  = 8'h30;
	localparam int CTRL_START = 0;
	localparam int CTRL_STOP  = 1;
	localparam int CTRL_HCLR  = 2;
	localparam int CTRL_MODE  = 4;
	localparam int CTRL_LIVE  = 6;
	localparam int CTRL_DIV   = 8;
	localparam logic [1:0]  RESP_OKAY   = 2'h0;
	localparam logic [1:0]  RESP_SLVERR = 2'h2;
	localparam logic [31:0] BITRATE_RST = 32'h0098F2F8;

	//------------------------------------------------------------------
	// Types
	//------------------------------------------------------------------
	typedef enum logic [1:0] {
		GATE_SINGLE  = 2'b00,
		GATE_REPEAT  = 2'b01,
		GATE_UNTIMED = 2'b10
	} bgc_mode_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_RUN  = 1'b1
	} bgc_st_t;

	typedef struct packed {
		logic       rec_ok;
		logic       sync_ok;
		logic       low_fit;
	} bgc_pins_t;

	typedef struct packed {
		bgc_st_t    st;
		bgc_mode_t  mode;
		logic       live;
		logic [2:0] div;
		logic [31:0] bitrate;
		logic [19:0] period;
		logic [31:0] tick;
		logic [31:0] live_cnt;
		logic [2:0] prog_cnt;
		logic [19:0] elapsed;
		logic [31:0] progress;
		logic [59:0] err;
		logic [59:0] bits;
		logic [59:0] pub_err;
		logic [59:0] pub_bits;
		logic [9:0] k_div;
		logic [31:0] k_acc;
		logic [31:0] khz;
		logic       sync_seen;
		logic       err_win;
		logic [2:0] alarm;
		logic [2:0] hist;
		logic       aw_held;
		logic       w_held;
		logic [7:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic       bvalid;
		logic [1:0] bresp;
		logic       rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} bgc_state_t;

endpackage

// ===== hw/bgc_pin_sync.sv
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module bgc_pin_sync import bgc_pkg::*; #(
	parameter int W = 3
) (
	// Clock and reset
	input  wire logic         i_sys_clk,
	input  wire logic         i_reset_n,
	// Pins and filtered levels
	input  wire logic [W-1:0] i_pin,
	output logic      [W-1:0] o_level
);

	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} bgc_sync_t;

	bgc_sync_t q;
	bgc_sync_t next_q;
	logic [W-1:0] agreed;

	// Stage one feeds only stage two; a change counts once two and three agree
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			assign agreed[g] = (q.s2[g] == q.s3[g]) ? q.s2[g] : q.q[g];
		end
	endgenerate

	always_comb begin
		next_q    = q;
		next_q.s1 = i_pin;
		next_q.s2 = q.s1;
		next_q.s3 = q.s2;
		next_q.q  = agreed;
	end

	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			q <= '0;
		end else begin
			q <= next_q;
		end
	end

	assign o_level = q.q;

endmodule

// ===== verif/bgc_props.sv
// Port-level assertions for the gated BER counter
`timescale 1ns/1ps
module bgc_props (
	// Clock and reset
	input wire logic        i_sys_clk,
	input wire logic        i_reset_n,
	// Register bus handshakes
	input wire logic        i_axi_awvalid,
	input wire logic        o_axi_awready,
	input wire logic        i_axi_wvalid,
	input wire logic        o_axi_wready,
	input wire logic        o_axi_bvalid,
	input wire logic        i_axi_bready,
	input wire logic        i_axi_arvalid,
	input wire logic        o_axi_arready,
	input wire logic        o_axi_rvalid,
	input wire logic        i_axi_rready,
	input wire logic [31:0] o_axi_rdata,
	// Bit stream, pins and status
	input wire logic        i_bit_valid,
	input wire logic        i_bit_error,
	input wire logic        i_clock_recovered,
	input wire logic        i_pattern_synced,
	input wire logic        o_running,
	input wire logic        o_error_alarm,
	input wire logic        o_recovery_unlocked_alarm,
	input wire logic        o_pattern_unlocked_alarm
);
	//------------------------------------------------------------
	// Properties
	//------------------------------------------------------------
	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_reset_n);

	// Pin levels pass a synchroniser, so eight stable cycles are allowed
	err_alarm_a: assert property (
		o_running && i_bit_valid && i_bit_error |-> ##[1:2] o_error_alarm)
		else $error("error alarm missing after a bit error");
	pat_clear_a: assert property (
		i_pattern_synced [*8] |-> !o_pattern_unlocked_alarm)
		else $error("pattern alarm while pattern is synchronised");
	rec_clear_a: assert property (
		i_clock_recovered [*8] |-> !o_recovery_unlocked_alarm)
		else $error("recovery alarm while clock is recovered");
	sync_clear_a: assert property (
		(o_running && i_pattern_synced) [*8] |->
		!o_recovery_unlocked_alarm && !o_pattern_unlocked_alarm)
		else $error("unlock alarms kept after sync in a run");
	bresp_hold_a: assert property (
		o_axi_bvalid && !i_axi_bready |=> o_axi_bvalid)
		else $error("write response dropped before bready");
	rdata_hold_a: assert property (
		o_axi_rvalid && !i_axi_rready |=> o_axi_rvalid && $stable(o_axi_rdata))
		else $error("read data changed before rready");
	wr_refuse_a: assert property (
		o_axi_bvalid |-> !o_axi_awready && !o_axi_wready)
		else $error("write accepted while a response is pending");
	wr_answer_a: assert property (
		i_axi_awvalid && o_axi_awready && i_axi_wvalid && o_axi_wready
		|-> ##[1:2] o_axi_bvalid)
		else $error("write response late");
	rd_answer_a: assert property (
		i_axi_arvalid && o_axi_arready |=> o_axi_rvalid)
		else $error("read data late");
endmodule

bind bgc_ber_gating_counter bgc_props props_u (.i_sys_clk, .i_reset_n,
	.i_axi_awvalid, .o_axi_awready, .i_axi_wvalid, .o_axi_wready,
	.o_axi_bvalid, .i_axi_bready, .i_axi_arvalid, .o_axi_arready,
	.o_axi_rvalid, .i_axi_rready, .o_axi_rdata, .i_bit_valid, .i_bit_error,
	.i_clock_recovered, .i_pattern_synced, .o_running, .o_error_alarm,
	.o_recovery_unlocked_alarm, .o_pattern_unlocked_alarm);

// ===== verif/bgc_pattern_src.sv
// Pattern source model: bursts of compared bits toward the counter
`timescale 1ns/1ps
module bgc_pattern_src #(
	parameter int unsigned ERR_EVERY = 4
) (
	// Clock and reset
	input  wire logic        i_sys_clk,
	input  wire logic        i_reset_n,
	// Burst request
	input  wire logic        i_go,
	input  wire logic [15:0] i_len,
	input  wire logic        i_slow,
	input  wire logic        i_clean,
	// Bit stream
	output logic             o_bit_valid,
	output logic             o_bit_error,
	output logic             o_busy
);
	logic [15:0] left;
	logic [15:0] idx;
	logic        ph;

	assign o_busy = (left != 16'h0000) || o_bit_valid;

	//------------------------------------------------------------
	// Bit sender
	//------------------------------------------------------------
	// Between bits the error line toggles, so an unqualified sample shows
	always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			left        <= 16'h0000;
			idx         <= 16'h0000;
			ph          <= 1'b0;
			o_bit_valid <= 1'b0;
			o_bit_error <= 1'b0;
		end else begin
			ph <= ~ph;
			if (i_go) begin
				left        <= i_len;
				idx         <= 16'h0000;
				o_bit_valid <= 1'b0;
				o_bit_error <= ~o_bit_error;
			end else if (left != 16'h0000 && (!i_slow || ph)) begin
				left        <= left - 16'h0001;
				idx         <= idx + 16'h0001;
				o_bit_valid <= 1'b1;
				o_bit_error <= !i_clean && (idx % ERR_EVERY == ERR_EVERY - 1);
			end else begin
				o_bit_valid <= 1'b0;
				o_bit_error <= ~o_bit_error;
			end
		end
	end
endmodule

// ===== verif/tb.sv
// Self-checking testbench for the gated BER counter
`timescale 1ns/1ps
module tb import bgc_pkg::*; ;
	logic        clk, rst_n, awv, wv, bry, arv, rry, go, slow, clean;
	logic        rec, syn, lowf, bval, berr, busy, awr, wrr, bv, arr, rv;
	logic        run, ea, ra, pa;
	logic [7:0]  awa, ara;
	logic [31:0] wd, rd;
	logic [3:0]  ws;
	logic [1:0]  br, rr;
	logic [15:0] len;
	int          error_cnt, checks_done, cyc, t0;

	bgc_ber_gating_counter #(.SEC_CYCLES(50), .LIVE_CYCLES(20)) dut_u (
		.i_sys_clk(clk), .i_reset_n(rst_n), .i_axi_awvalid(awv),
		.o_axi_awready(awr), .i_axi_awaddr(awa), .i_axi_wvalid(wv),
		.o_axi_wready(wrr), .i_axi_wdata(wd), .i_axi_wstrb(ws),
		.o_axi_bvalid(bv), .i_axi_bready(bry), .o_axi_bresp(br),
		.i_axi_arvalid(arv), .o_axi_arready(arr), .i_axi_araddr(ara),
		.o_axi_rvalid(rv), .i_axi_rready(rry), .o_axi_rdata(rd),
		.o_axi_rresp(rr), .i_bit_valid(bval), .i_bit_error(berr),
		.i_clock_recovered(rec), .i_pattern_synced(syn),
		.i_low_rate_fitted(lowf), .o_running(run), .o_error_alarm(ea),
		.o_recovery_unlocked_alarm(ra), .o_pattern_unlocked_alarm(pa));
	bgc_pattern_src #(.ERR_EVERY(4)) src_u (.i_sys_clk(clk),
		.i_reset_n(rst_n), .i_go(go), .i_len(len), .i_slow(slow),
		.i_clean(clean), .o_bit_valid(bval), .o_bit_error(berr),
		.o_busy(busy));

	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	always @(posedge clk) cyc <= cyc + 1;

	//------------------------------------------------------------
	// Shared tasks
	//------------------------------------------------------------
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			error_cnt++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic stop_test;
		$display("mismatches %0d comparisons %0d", error_cnt, checks_done);
		if (error_cnt == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// Handshake state is sampled at the falling edge, clear of update races
	task automatic bus(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q, output logic [1:0] r);
		logic pnd_a, pnd_w, ta, tw, done;
		int n;
		pnd_a = 1'b1;
		pnd_w = w;
		done = 1'b0;
		n = 0;
		@(posedge clk);
		awv <= w;
		wv <= w;
		arv <= !w;
		awa <= a;
		ara <= a;
		wd <= d;
		bry <= w;
		rry <= !w;
		while (!done && n < 100) begin
			@(negedge clk);
			done = w ? bv : rv;
			r = w ? br : rr;
			q = rd;
			ta = pnd_a && (w ? awr : arr);
			tw = pnd_w && wrr;
			@(posedge clk);
			n++;
			if (ta) awv <= 1'b0;
			if (ta) arv <= 1'b0;
			if (tw) wv <= 1'b0;
			pnd_a = pnd_a && !ta;
			pnd_w = pnd_w && !tw;
		end
		bry <= 1'b0;
		rry <= 1'b0;
		check({31'h0, done}, 32'h00000001);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b1, a, d, q, r);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		logic [1:0]  r;
		bus(1'b0, a, 32'h0, q, r);
		check(q, e);
	endtask
	task automatic ctl(input logic [1:0] m, input logic [2:0] dv,
		input logic lv, input logic [2:0] c);
		wr(OFS_CTRL, {21'h0, dv, 1'b0, lv, m, 1'b0, c});
	endtask
	task automatic burst(input logic [15:0] l, input logic s, input logic c);
		int n;
		n = 0;
		@(posedge clk);
		go <= 1'b1;
		len <= l;
		slow <= s;
		clean <= c;
		@(posedge clk);
		go <= 1'b0;
		do begin
			@(negedge clk);
			n++;
		end while (busy && n < 5000);
	endtask

	//------------------------------------------------------------
	// Scenarios
	//------------------------------------------------------------
	task automatic sc_regs;
		logic [31:0] q;
		logic [1:0]  r;
		rd_chk(OFS_BITRATE, 32'h0098F2F8);
		rd_chk(OFS_PERIOD, 32'h0000003C);
		bus(1'b0, 8'h40, 32'h0, q, r);
		check({q[29:0], r}, {30'h0, RESP_SLVERR});
		bus(1'b1, 8'h44, 32'h1, q, r);
		check({30'h0, r}, {30'h0, RESP_SLVERR});
		wr(OFS_PERIOD, 32'h00000000);
		rd_chk(OFS_PERIOD, 32'h00000001);
		wr(OFS_PERIOD, 32'h000FFFFF);
		rd_chk(OFS_PERIOD, 32'h000D2EFF);
		ctl(GATE_UNTIMED, 3'h0, 1'b0, 3'h0);
		wr(OFS_PERIOD, 32'h00000005);
		rd_chk(OFS_PERIOD, 32'h000D2EFF);
	endtask
	task automatic sc_single;
		ctl(GATE_SINGLE, 3'h0, 1'b0, 3'h0);
		wr(OFS_PERIOD, 32'h00000002);
		ctl(GATE_SINGLE, 3'h0, 1'b0, 3'h1);
		t0 = cyc;
		burst(16'h0020, 1'b1, 1'b0);
		check({31'h0, pa}, 32'h1);
		rd_chk(OFS_ERR_LO, 32'h00000000);
		while (run && cyc < t0 + 400) @(negedge clk);
		check({31'h0, (cyc - t0 >= 50) && (cyc - t0 <= 104)}, 32'h1);
		rd_chk(OFS_ERR_LO, 32'h00000008);
		rd_chk(OFS_BITS_LO, 32'h00000020);
		rd_chk(OFS_ELAPSED, 32'h00000000);
		rd_chk(OFS_REMAIN, 32'h00000002);
		rd_chk(OFS_RATIO, 32'h00000001);
	endtask
	task automatic sc_untimed;
		@(posedge clk);
		syn <= 1'b1;
		lowf <= 1'b1;
		repeat (10) @(negedge clk);
		check({31'h0, ra}, 32'h1);
		ctl(GATE_UNTIMED, 3'h0, 1'b0, 3'h1);
		t0 = cyc;
		burst(16'h0010, 1'b0, 1'b0);
		check({30'h0, ra, pa}, 32'h0);
		while (cyc < t0 + 270) @(posedge clk);
		rd_chk(OFS_PROGRESS, 32'h00000005);
		// Last run's published total stands until this run stops
		rd_chk(OFS_ERR_LO, 32'h00000008);
		burst(16'h0010, 1'b0, 1'b0);
		ctl(GATE_UNTIMED, 3'h0, 1'b0, 3'h2);
		rd_chk(OFS_ERR_LO, 32'h00000008);
		ctl(GATE_UNTIMED, 3'h0, 1'b0, 3'h1);
		burst(16'h04B0, 1'b0, 1'b1);
		ctl(GATE_UNTIMED, 3'h0, 1'b0, 3'h2);
		rd_chk(OFS_ERR_LO, 32'h00000000);
		rd_chk(OFS_BITS_LO, 32'h000004B0);
		rd_chk(OFS_RATIO, 32'h80000003);
	endtask
	task automatic sc_repeat;
		ctl(GATE_REPEAT, 3'h0, 1'b1, 3'h0);
		wr(OFS_PERIOD, 32'h00000001);
		ctl(GATE_REPEAT, 3'h0, 1'b1, 3'h1);
		t0 = cyc;
		burst(16'h0008, 1'b0, 1'b0);
		repeat (25) @(posedge clk);
		rd_chk(OFS_ERR_LO, 32'h00000002);
		while (cyc < t0 + 80) @(posedge clk);
		rd_chk(OFS_ERR_LO, 32'h00000000);
		check({31'h0, run}, 32'h1);
		ctl(GATE_REPEAT, 3'h0, 1'b1, 3'h2);
	endtask
	task automatic sc_alarm;
		logic [31:0] q;
		logic [1:0]  r;
		@(posedge clk);
		rec <= 1'b1;
		repeat (10) @(posedge clk);
		bus(1'b0, OFS_STATUS, 32'h0, q, r);
		check({26'h0, q[7:2]}, 32'h00000038);
		ctl(GATE_REPEAT, 3'h0, 1'b1, 3'h4);
		bus(1'b0, OFS_STATUS, 32'h0, q, r);
		check({26'h0, q[7:2]}, 32'h00000000);
		ctl(GATE_REPEAT, 3'h2, 1'b1, 3'h0);
		rec <= 1'b0;
		repeat (10) @(negedge clk);
		check({31'h0, ra}, 32'h0);
		ctl(GATE_REPEAT, 3'h1, 1'b1, 3'h0);
		repeat (10) @(negedge clk);
		check({31'h0, ra}, 32'h1);
		wr(OFS_BITRATE, 32'h002FAF08);
		repeat (10) @(negedge clk);
		check({31'h0, ra}, 32'h0);
	endtask

	initial begin
		{rst_n, awv, wv, bry, arv, rry, go, slow, clean} = 9'h000;
		{rec, syn, lowf, awa, ara, wd, len} = 67'h0;
		ws = 4'hF;
		cyc = 0;
		error_cnt = 0;
		checks_done = 0;
		repeat (3) @(posedge clk);
		rst_n <= 1'b1;
		sc_regs;
		sc_single;
		sc_untimed;
		sc_repeat;
		sc_alarm;
		stop_test;
	end
	// The full run needs about 1900 cycles; over five times that is allowed
	initial begin
		#200000;
		error_cnt++;
		stop_test;
	end
endmodule
